/* File: include/bzm_pkg.sv */
// Purpose: Shared constants and types for the buzzer and melody tone generator
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Register indices are word numbers; the byte address is four times the index

package bzm_pkg;

   // Bus geometry
   localparam int APB_AW = 18;
   localparam int APB_DW = 32;

   // Register indices (byte address = index * 4)
   localparam logic [15:0] IDX_A_DIV_LO = 16'hA040;
   localparam logic [15:0] IDX_A_DIV_HI = 16'hA041;
   localparam logic [15:0] IDX_A_DUR = 16'hA042;
   localparam logic [15:0] IDX_A_PAU = 16'hA043;
   localparam logic [15:0] IDX_B_DIV_LO = 16'hA044;
   localparam logic [15:0] IDX_B_DIV_HI = 16'hA045;
   localparam logic [15:0] IDX_B_DUR = 16'hA046;
   localparam logic [15:0] IDX_B_PAU = 16'hA047;
   localparam logic [15:0] IDX_CFG = 16'hA048;
   localparam logic [15:0] IDX_POW = 16'hA049;
   localparam logic [15:0] IDX_TU = 16'hA04A;
   localparam logic [15:0] SLOT_STRIDE = 16'h0004;

   // Reset value shared by every register
   localparam logic [7:0] REG_RST = 8'h00;

   // Field positions of buzzer_config_control
   localparam int CFG_EN = 7;
   localparam int CFG_POL = 6;
   localparam int CFG_IEB = 5;
   localparam int CFG_IEA = 4;
   localparam int CFG_FB = 3;
   localparam int CFG_FA = 2;
   localparam int CFG_STB = 1;
   localparam int CFG_STA = 0;

   // Field positions of time_unit_control
   localparam int TU_HI = 7;
   localparam int TU_LO = 6;
   localparam int TU_TONE_BASE_SELECT = 4;
   localparam int TU_IEP = 1;
   localparam int TU_FP = 0;

   // Tone base: half periods of the /32 and /64 base clocks
   localparam logic [5:0] HALF_LAST_32 = 6'h0F;
   localparam logic [5:0] HALF_LAST_64 = 6'h1F;

   // Time unit base step
   localparam int CLK_PERIOD_NS = 40;
   localparam int UNIT_BASE_NS = 1000000;
   localparam int UNIT_BASE_CYCLES = UNIT_BASE_NS / CLK_PERIOD_NS;

   // One note slot
   typedef struct packed {
      logic [11:0] div;
      logic [7:0] dur;
      logic [7:0] pau;
   } bzm_note_t;

   typedef enum {ST_IDLE, ST_TONE, ST_PAUSE} bzm_state_t;

endpackage : bzm_pkg

/* File: hw/bzm_unit_tick.sv */
// Purpose: Time unit tick for duration, pause and power window timing
// Assumes: Base step counted from pclk, unit of 1, 2, 4 or 8 base steps
// Notes: A synchronous clear realigns the unit to the start of a note
`timescale 1ns/1ps

module bzm_unit_tick
   import bzm_pkg::*;
#(
   parameter int MS_CYCLES = UNIT_BASE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   input wire logic clr,
   input wire logic [1:0] tu,
   output logic tick_q
);
   localparam int MS_W = $clog2(MS_CYCLES);

   logic [MS_W-1:0] ms_cnt_q;
   logic [2:0] unit_cnt_q;
   logic [3:0] unit_len;
   logic [2:0] unit_last;
   logic ms_done;

   // Unit length in base steps from the code
   assign unit_len = 4'h1 << tu; // [R5]
   assign unit_last = 3'(unit_len - 4'h1);
   assign ms_done = (ms_cnt_q == MS_W'(MS_CYCLES - 1));

   // Counters; >= guards against a unit code shrinking mid count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt_q <= '0;
         unit_cnt_q <= 3'h0;
         tick_q <= 1'b0;
      end else if (pce) begin
         if (clr) begin
            ms_cnt_q <= '0;
            unit_cnt_q <= 3'h0;
            tick_q <= 1'b0;
         end else begin
            ms_cnt_q <= ms_done ? '0 : ms_cnt_q + 1'b1;
            tick_q <= ms_done && (unit_cnt_q >= unit_last); // [R5]
            if (ms_done) begin
               unit_cnt_q <= (unit_cnt_q >= unit_last) ? 3'h0 : unit_cnt_q + 3'h1;
            end
         end
      end
   end

   // A clear always suppresses the next tick
   a_unit_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
      (pce && clr) |=> !tick_q) else $error("tick after clear");

endmodule : bzm_unit_tick

/* File: hw/bzm_top.sv */
// Purpose: Buzzer and melody tone generator with two ping-pong note slots
// Assumes: APB slave on pclk, one clock domain, pce freezes all state
// Notes: Time unit counted from pclk; outputs come straight from flip-flops
// What this block does
// [R1] Two note slots A and B, each with divider, duration and pause.
// [R2] Tone base clock is system clock over 32, or over 64 when base select set.
// [R3] Tone frequency is base clock over twelve-bit divider plus one.
// [R4] Tone lasts duration times unit; following silence lasts pause times unit.
// [R5] Time unit codes give 1, 2, 4 or 8 ms, independent of tone.
// [R6] Power window timer restarts when note A or B playback begins.
// [R7] Window expiry sets its flag; interrupt requested when its enable set.
// [R8] Software clears the power window flag; hardware holds it until then.
// [R9] Controller enable bit turns the controller on; clearing turns it off.
// [R10] Polarity bit set inverts the buzzer output.
// [R11] Note A completion with its enable set raises A flag; write 0 clears.
// [R12] Note B completion with its enable set raises B flag; write 0 clears.
// [R13] Writing 1 starts note A; writing 0 ignored; bit clears at note end.
// [R14] Writing 1 starts note B; writing 0 ignored; bit clears at note end.
// [R15] Both starts written together play A first, then B directly after.
// [R16] Start bit positions read back busy while that note is playing.
// [R17] Notes play once in sequence or alternate while software refills slots.
// [R18] Square wave at tone frequency during tone; inactive level during pause.
// [R19] Power control active from note start until window timer expires.
// [R20] All registers reset to zero: disabled, idle, flags clear.
`timescale 1ns/1ps

module bzm_top
   import bzm_pkg::*;
#(
   parameter int MS_CYCLES = UNIT_BASE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [APB_DW-1:0] pwdata,
   output logic [APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic buzzer_output,
   output logic power_on_window,
   output logic irq
);

   // Register state
   bzm_note_t slot_q [2];
   logic [7:0] pow_q;
   logic [1:0] tu_q;
   logic tone_base_select_q, iep_q, fp_q;
   logic en_q, pol_q, ieb_q, iea_q, fb_q, fa_q, sa_q, sb_q;

   // Sequencer state
   bzm_state_t st_q;
   logic cur_q;
   logic [7:0] tcnt_q;
   logic [5:0] half_cnt_q;
   logic [11:0] ph_cnt_q;
   logic wave_q;
   logic [7:0] powcnt_q;
   logic bz_q, irq_q, pready_q, pslverr_q;
   logic [APB_DW-1:0] prdata_q;

   // Bus decode
   logic [15:0] widx;
   logic access, wr, sel_cfg, sel_pow, sel_tu, hit;
   logic [1:0] sel_lo, sel_hi, sel_dur, sel_pau;
   logic [7:0] rd_byte;
   logic [7:0] slot_rd [2];

   assign widx = paddr[17:2];
   assign access = psel && penable && pready_q;
   assign wr = access && pwrite;
   assign sel_cfg = (widx == IDX_CFG);
   assign sel_pow = (widx == IDX_POW);
   assign sel_tu = (widx == IDX_TU);

   // Per-slot decode, read mux and register write
   for (genvar s = 0; s < 2; s++) begin : g_slot
      localparam logic [15:0] BASE = IDX_A_DIV_LO + 16'(s) * SLOT_STRIDE;
      assign sel_lo[s] = (widx == BASE);
      assign sel_hi[s] = (widx == BASE + (IDX_A_DIV_HI - IDX_A_DIV_LO));
      assign sel_dur[s] = (widx == BASE + (IDX_A_DUR - IDX_A_DIV_LO));
      assign sel_pau[s] = (widx == BASE + (IDX_A_PAU - IDX_A_DIV_LO));
      assign slot_rd[s] = sel_lo[s] ? slot_q[s].div[7:0] :
                          sel_hi[s] ? {4'h0, slot_q[s].div[11:8]} :
                          sel_dur[s] ? slot_q[s].dur :
                          sel_pau[s] ? slot_q[s].pau : 8'h00;

      // Slot registers, written only at the completing access edge
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            slot_q[s] <= '0; // [R20]
         end else if (pce && wr) begin
            if (sel_lo[s]) slot_q[s].div[7:0] <= pwdata[7:0]; // [R1]
            if (sel_hi[s]) slot_q[s].div[11:8] <= pwdata[3:0];
            if (sel_dur[s]) slot_q[s].dur <= pwdata[7:0];
            if (sel_pau[s]) slot_q[s].pau <= pwdata[7:0];
         end
      end
   end

   assign hit = |{sel_lo, sel_hi, sel_dur, sel_pau, sel_cfg, sel_pow, sel_tu};

   // Status readback; start positions show busy
   logic playing_a, playing_b;
   assign playing_a = (st_q != ST_IDLE) && !cur_q; // [R16]
   assign playing_b = (st_q != ST_IDLE) && cur_q; // [R16]
   assign rd_byte = sel_cfg ? {en_q, pol_q, ieb_q, iea_q, fb_q, fa_q, playing_b, playing_a} :
                    sel_pow ? pow_q :
                    sel_tu ? {tu_q, 1'b0, tone_base_select_q, 2'b00, iep_q, fp_q} :
                    (slot_rd[0] | slot_rd[1]);

   // APB answer: one wait state, error on unmapped words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else if (pce) begin
         pready_q <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !hit;
         prdata_q <= (psel && penable && !pready_q) ? {24'h000000, rd_byte} : '0;
      end
   end

   // Plain configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pow_q <= REG_RST;
         {tu_q, tone_base_select_q, iep_q} <= 4'h0;
         {en_q, pol_q, ieb_q, iea_q} <= 4'h0; // [R20]
      end else if (pce && wr) begin
         if (sel_pow) pow_q <= pwdata[7:0];
         if (sel_tu) {tu_q, tone_base_select_q, iep_q} <= {pwdata[TU_HI:TU_LO], pwdata[TU_TONE_BASE_SELECT], pwdata[TU_IEP]};
         if (sel_cfg) {en_q, pol_q, ieb_q, iea_q} <= pwdata[CFG_EN:CFG_IEA]; // [R9] [R10]
      end
   end

   // Sequencer control terms
   bzm_note_t cur_note, new_note;
   logic unit_tick, half_tick, ph_wrap, done, idle_go, begin_note, new_cur, other_pend;
   logic wr_cfg;
   assign wr_cfg = wr && sel_cfg;
   assign cur_note = slot_q[cur_q];
   assign half_tick = (half_cnt_q == (tone_base_select_q ? HALF_LAST_64 : HALF_LAST_32)); // [R2]
   assign ph_wrap = half_tick && (ph_cnt_q == cur_note.div); // [R3]
   assign done = (st_q == ST_PAUSE) && (tcnt_q == 8'h00);
   assign other_pend = cur_q ? sa_q : sb_q; // [R17]
   assign idle_go = (st_q == ST_IDLE) && en_q && (sa_q || sb_q);
   assign begin_note = idle_go || (done && en_q && other_pend);
   assign new_cur = idle_go ? !sa_q : !cur_q; // [R15]
   assign new_note = slot_q[new_cur];

   // Time unit shared by duration, pause and power window
   bzm_unit_tick #(
      .MS_CYCLES(MS_CYCLES)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .pce(pce),
      .clr(begin_note),
      .tu(tu_q),
      .tick_q(unit_tick)
   );

   // Note state machine; disabling aborts at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
         cur_q <= 1'b0;
         tcnt_q <= 8'h00;
      end else if (pce) begin
         if (!en_q) begin
            st_q <= ST_IDLE; // [R9]
         end else if (begin_note) begin
            st_q <= ST_TONE;
            cur_q <= new_cur; // [R15] [R17]
            tcnt_q <= new_note.dur; // [R4]
         end else begin
            case (st_q)
               ST_TONE: begin
                  if (tcnt_q == 8'h00) begin
                     st_q <= ST_PAUSE;
                     tcnt_q <= cur_note.pau; // [R4]
                  end else if (unit_tick) begin
                     tcnt_q <= tcnt_q - 8'h01;
                  end
               end
               ST_PAUSE: begin
                  if (done) begin
                     st_q <= ST_IDLE;
                  end else if (unit_tick) begin
                     tcnt_q <= tcnt_q - 8'h01;
                  end
               end
               ST_IDLE: st_q <= ST_IDLE;
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Square wave: toggles every divider+1 half periods of the base clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_cnt_q <= 6'h00;
         ph_cnt_q <= 12'h000;
         wave_q <= 1'b0;
      end else if (pce) begin
         if (begin_note || st_q != ST_TONE) begin
            half_cnt_q <= 6'h00;
            ph_cnt_q <= 12'h000;
            wave_q <= 1'b0; // [R18]
         end else begin
            half_cnt_q <= half_tick ? 6'h00 : half_cnt_q + 6'h01; // [R2]
            if (ph_wrap) begin
               ph_cnt_q <= 12'h000;
               wave_q <= !wave_q; // [R3] [R18]
            end else if (half_tick) begin
               ph_cnt_q <= ph_cnt_q + 12'h001;
            end
         end
      end
   end

   // Start bits and end flags; a hardware set wins over a software clear
   logic fa_set, fb_set, fp_set;
   assign fa_set = done && !cur_q && iea_q; // [R11]
   assign fb_set = done && cur_q && ieb_q; // [R12]
   assign fp_set = power_on_window && (powcnt_q == 8'h00); // [R7]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {sa_q, sb_q, fa_q, fb_q, fp_q} <= 5'h00;
      end else if (pce) begin
         sa_q <= (wr_cfg && pwdata[CFG_EN] && pwdata[CFG_STA]) ||
                 (sa_q && en_q && !(done && !cur_q)); // [R13]
         sb_q <= (wr_cfg && pwdata[CFG_EN] && pwdata[CFG_STB]) ||
                 (sb_q && en_q && !(done && cur_q)); // [R14]
         fa_q <= fa_set || (fa_q && !(wr_cfg && !pwdata[CFG_FA])); // [R11]
         fb_q <= fb_set || (fb_q && !(wr_cfg && !pwdata[CFG_FB])); // [R12]
         fp_q <= fp_set || (fp_q && !(wr && sel_tu && !pwdata[TU_FP])); // [R8]
      end
   end

   // Power window timer and registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_on_window <= 1'b0;
         powcnt_q <= 8'h00;
         bz_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (pce) begin
         if (!en_q) begin
            power_on_window <= 1'b0;
         end else if (begin_note) begin
            power_on_window <= 1'b1; // [R6] [R19]
            powcnt_q <= pow_q;
         end else if (power_on_window) begin
            if (powcnt_q == 8'h00) power_on_window <= 1'b0; // [R19]
            else if (unit_tick) powcnt_q <= powcnt_q - 8'h01;
         end
         bz_q <= wave_q ^ pol_q; // [R10]
         irq_q <= (fp_q && iep_q) || fa_q || fb_q; // [R7]
      end
   end

   assign buzzer_output = bz_q;
   assign irq = irq_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // Checks
   a_start_arm: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      (pce && wr_cfg && pwdata[CFG_EN] && pwdata[CFG_STA]) |=> sa_q)
      else $error("start A lost");
   a_a_first: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
      (pce && idle_go && sa_q && sb_q) |=> playing_a)
      else $error("B played before A");
   a_polarity_idle: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
      ($past(pce) && $past(st_q, 2) != ST_TONE && $past(pce, 2)) |-> bz_q == $past(pol_q))
      else $error("bad idle level");
   a_flag_a_set: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      (pce && done && !cur_q && iea_q) |=> fa_q)
      else $error("A end flag missed");
   a_flag_b_set: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
      (pce && done && cur_q && ieb_q) |=> fb_q)
      else $error("B end flag missed");
   a_pow_expire: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
      (pce && !begin_note && en_q && fp_set) |=> (fp_q && !power_on_window))
      else $error("window expiry wrong");
   a_disable_idle: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      (pce && !en_q) |=> (st_q == ST_IDLE && !power_on_window))
      else $error("runs while disabled");
   a_pow_restart: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
      (pce && begin_note) |=> (power_on_window && powcnt_q == $past(pow_q)))
      else $error("window not restarted");
   a_wave_steady: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      (pce && st_q == ST_TONE && !ph_wrap && !begin_note && en_q) |=> wave_q == $past(wave_q))
      else $error("wave toggled early");

   // Start bits: a zero write changes nothing, completion clears the bit
   a_start_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      (pce && wr_cfg && !pwdata[CFG_STA] && !sa_q) |=> !sa_q)
      else $error("start A set by a zero");
   a_start_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      (pce && wr_cfg && sa_q && en_q && !done) |=> sa_q)
      else $error("start A lost while busy");
   a_a_end_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      (pce && done && !cur_q && !wr_cfg) |=> !sa_q)
      else $error("start A not cleared");
   a_b_end_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
      (pce && done && cur_q && !wr_cfg) |=> !sb_q)
      else $error("start B not cleared");

   // Sequencing: no idle cycle between the two notes, in either direction
   a_b_follows: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
      (pce && en_q && done && !cur_q && sb_q) |=> (st_q == ST_TONE && cur_q))
      else $error("B did not follow A");
   a_ping_pong: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
      (pce && en_q && done && cur_q && sa_q) |=> (st_q == ST_TONE && !cur_q))
      else $error("A did not follow B");

   // Timing: counts move only on a unit tick, so a slow unit cannot be skipped
   a_count_steady: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
      (pce && en_q && !begin_note && st_q != ST_IDLE && tcnt_q != 8'h00 && !unit_tick) |=> tcnt_q == $past(tcnt_q))
      else $error("count moved without tick");
   a_tone_end: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
      (pce && en_q && !begin_note && st_q == ST_TONE && tcnt_q == 8'h00) |=> st_q == ST_PAUSE)
      else $error("tone did not turn to pause");
   a_base_wrap: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      (pce && st_q == ST_TONE && !begin_note && half_tick) |=> half_cnt_q == 6'h00)
      else $error("base step did not wrap");
   a_pause_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
      (pce && st_q == ST_PAUSE) |=> !wave_q)
      else $error("wave active in pause");

   // Window and flags: the window never rises without a note start
   a_pow_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
      (pce && !power_on_window && !begin_note) |=> !power_on_window)
      else $error("window rose without start");
   a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
      (pce && fp_q && !(wr && sel_tu && !pwdata[TU_FP])) |=> fp_q)
      else $error("window flag dropped");
   a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
      (pce && wr && sel_tu && !pwdata[TU_FP] && !fp_set) |=> !fp_q)
      else $error("window flag not cleared");
   a_irq_request: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
      (pce && fp_q && iep_q) |=> irq)
      else $error("window interrupt missing");

endmodule : bzm_top

/* File: test/bzm_buzzer_model.sv */
// Purpose: Buzzer element and power switch seen from the block's pins
// Assumes: One pclk domain, both pins sampled on the rising edge
// Notes: Counts restart at each rise of the power switch
`timescale 1ns/1ps

module bzm_buzzer_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic buzzer_output,
   input wire logic power_on_window,
   output int half_cyc,
   output int on_cyc,
   output int toggles
);
   logic last_q;
   logic pow_q;
   int run_q;
   wire edge_seen = (buzzer_output != last_q);

   // Half period, powered time and toggles of one session
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_q <= 1'b0;
         pow_q <= 1'b0;
         run_q <= 0;
         half_cyc <= 0;
         on_cyc <= 0;
         toggles <= 0;
      end else begin
         last_q <= buzzer_output;
         pow_q <= power_on_window;
         run_q <= edge_seen ? 0 : run_q + 1;
         if (edge_seen) begin
            half_cyc <= run_q + 1;
         end
         if (power_on_window && !pow_q) begin
            on_cyc <= 1;
            toggles <= 0;
         end else begin
            on_cyc <= on_cyc + (power_on_window ? 1 : 0);
            toggles <= toggles + (edge_seen ? 1 : 0);
         end
      end
   end
endmodule : bzm_buzzer_model

/* File: test/tb_buzzer_melody_tone_generator.sv */
// Purpose: Self-checking bench for the buzzer and melody tone generator
// Assumes: APB master tasks; time unit shortened to 100 cycles
// Notes: Session lengths allow a few cycles of polling slack
`timescale 1ns/1ps

module tb_buzzer_melody_tone_generator
   import bzm_pkg::*;
;
   localparam int MSC = 100;
   logic pclk;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = '0;
   logic [APB_DW-1:0] pwdata = '0;
   logic [APB_DW-1:0] prdata;
   logic [APB_DW-1:0] rd;
   logic pready, pslverr, buzzer_output, power_on_window, irq, err;
   logic [1:0] fb;
   int half_cyc, on_cyc, toggles, el;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [15:0] regs [11] = '{IDX_A_DIV_LO, IDX_A_DIV_HI, IDX_A_DUR, IDX_A_PAU, IDX_B_DIV_LO, IDX_B_DIV_HI,
      IDX_B_DUR, IDX_B_PAU, IDX_POW, IDX_CFG, IDX_TU};

   bzm_top #(.MS_CYCLES(MSC)) dut_u (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .buzzer_output(buzzer_output), .power_on_window(power_on_window), .irq(irq));
   bzm_buzzer_model part_u (.pclk(pclk), .presetn(presetn), .buzzer_output(buzzer_output),
      .power_on_window(power_on_window), .half_cyc(half_cyc), .on_cyc(on_cyc), .toggles(toggles));

   // 25 MHz clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // Hang guard, far above the planned run of some three thousand cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         conclude();
      end
   end

   task automatic conclude();
      $display("Checks %0d, errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_in(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
      end
   endtask : chk_in

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) error_cnt++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Start by a control write, then poll busy until the session ends
   task automatic run_note(input logic [7:0] c, output int el, output logic [1:0] fb);
      int t0, n;
      t0 = cyc;
      n = 0;
      apb(1'b1, IDX_CFG, c);
      apb(1'b0, IDX_CFG, 8'h00);
      fb = rd[1:0];
      while (rd[1:0] !== 2'b00 && n < 400) begin
         apb(1'b0, IDX_CFG, 8'h00);
         n++;
      end
      if (n >= 400) error_cnt++;
      el = cyc - t0;
   endtask : run_note

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk({buzzer_output, power_on_window, irq}, 32'h0);
      for (int i = 0; i < 11; i++) begin
         apb(1'b0, regs[i], 8'h00);
         chk(rd, 32'h0);
      end
      // Unmapped word reads zero with an error response
      apb(1'b0, 16'hA04B, 8'h00);
      chk(rd, 32'h0);
      chk(err, 32'h1);
      for (int i = 0; i < 9; i++) begin
         apb(1'b1, regs[i], 8'(i + 3));
         apb(1'b0, regs[i], 8'h00);
         chk(rd, 32'(i + 3));
      end
      // Single note A: divider 1, four units tone, two units pause
      apb(1'b1, IDX_A_DIV_LO, 8'h01);
      apb(1'b1, IDX_A_DIV_HI, 8'h00);
      apb(1'b1, IDX_A_DUR, 8'h04);
      apb(1'b1, IDX_A_PAU, 8'h02);
      apb(1'b1, IDX_POW, 8'h02);
      apb(1'b1, IDX_TU, 8'h02);
      run_note(8'h91, el, fb);
      chk(fb, 32'h1);
      chk_in(el, 600, 616);
      chk(half_cyc, 32'd32);
      chk_in(on_cyc, 198, 206);
      chk_in(toggles, 11, 13);
      chk(rd, 32'h94);
      apb(1'b1, IDX_CFG, 8'h90);
      apb(1'b0, IDX_CFG, 8'h00);
      chk(rd, 32'h90);
      chk(irq, 32'h1);
      apb(1'b0, IDX_TU, 8'h00);
      chk(rd, 32'h03);
      apb(1'b1, IDX_TU, 8'h03);
      apb(1'b0, IDX_TU, 8'h00);
      chk(rd, 32'h03);
      apb(1'b1, IDX_TU, 8'h02);
      apb(1'b0, IDX_TU, 8'h00);
      chk(rd, 32'h02);
      chk(irq, 32'h0);
      // Every time unit code on a one-unit note
      apb(1'b1, IDX_A_DUR, 8'h01);
      apb(1'b1, IDX_A_PAU, 8'h00);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, IDX_TU, 8'(k << 6));
         run_note(8'h81, el, fb);
         chk_in(el, MSC << k, (MSC << k) + 16);
      end
      // Both starts at once, base /64, inverted output
      apb(1'b1, IDX_TU, 8'h10);
      apb(1'b1, IDX_B_DIV_LO, 8'h00);
      apb(1'b1, IDX_B_DIV_HI, 8'h00);
      // Two units, so B's last half period ends on a toggle, not cut by the pause
      apb(1'b1, IDX_B_DUR, 8'h02);
      apb(1'b1, IDX_B_PAU, 8'h01);
      run_note(8'hF3, el, fb);
      chk(fb, 32'h1);
      chk_in(el, 400, 416);
      chk(half_cyc, 32'd32);
      chk(rd, 32'hFC);
      chk(buzzer_output, 32'h1);
      // Refill B alone, then abort by clearing the enable
      apb(1'b1, IDX_B_DUR, 8'hFF);
      apb(1'b1, IDX_CFG, 8'hC2);
      apb(1'b0, IDX_CFG, 8'h00);
      chk(rd, 32'hC2);
      chk(power_on_window, 32'h1);
      apb(1'b1, IDX_CFG, 8'h00);
      apb(1'b0, IDX_CFG, 8'h00);
      chk(rd, 32'h0);
      chk(power_on_window, 32'h0);
      apb(1'b1, IDX_CFG, 8'h01);
      apb(1'b0, IDX_CFG, 8'h00);
      chk(rd, 32'h0);
      conclude();
   end
endmodule : tb_buzzer_melody_tone_generator
